// File: hdl/program_loop_watchdog.sv
// program loop watchdog: mode and restart key registers, interval counter, reset request
// assumes ring and crystal clocks arrive as raw pins and power state comes from core clock logic
`timescale 1ns/10ps
`default_nettype none

// Summary of operation
// - mode register takes one write after reset, reads freely, resets to 67H
// - a second mode write while running raises the internal reset
// - bits 4:3 pick ring clock, crystal clock, or stop counting
// - bits 2:0 set overflow at ring/2^11 or crystal/2^13, doubling per step
// - after reset counting starts at once on ring clock, longest interval
// - every mode register write gets one wait cycle
// - any accepted mode write clears the counter
// - writing ACH to the restart register clears the counter, counting resumes
// - any other restart register value raises the internal reset
// - a single-bit access to the restart register raises the internal reset
// - restart register always reads 9AH
// - non-stoppable option ignores bits 4:3 and always counts on ring clock
// - non-stoppable option keeps counting in every state including STOP
// - counter overflow of the chosen interval raises the internal reset
// - while stopped, second writes, bit accesses and bad keys cause no reset
// - stoppable option pauses in HALT and STOP, holding the count
// - a watchdog reset sets the watchdog flag of the reset-cause register
// - crystal counting gets no ticks while crystal stopped, halted or stabilizing
module program_loop_watchdog
  import guard_timer_pkg::*;
#(
  parameter bit RING_NONSTOP = 1'b0
)(
  // clock and reset
  input  wire logic                     core_clk,
  input  wire logic                     rst_n,
  // register access
  input  wire guard_timer_pkg::bus_req_t bus,
  output logic [7:0]                    bus_rdata,
  output logic                          bus_wait,
  // counting clock pins
  input  wire logic                     ring_osc_in,
  input  wire logic                     crystal_in,
  // processor power state
  input  wire guard_timer_pkg::power_state_t pwr,
  // reset outputs
  output logic                          wdt_reset_req,
  output logic                          guard_reset_cause_flag
);
  import guard_timer_pkg::*;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [COUNT_W-1:0] terminal_count(input logic [4:0] m);
    int exp;
    exp = (m[CLOCK_SOURCE_POS] ? XTAL_BASE_EXP : RING_BASE_EXP) + int'(m[INTERVAL_MSB:0]);
    terminal_count = ~({COUNT_W{1'b1}} << exp);
  endfunction

  // rising edge of a synchronised pin, shared by both counting clocks
  function automatic logic rising(input logic now_level, input logic last_level);
    rising = now_level && !last_level;
  endfunction

  wdt_state_t state;
  wdt_state_t next_state;

  logic mode_access;
  logic mode_commit;
  logic key_access;
  logic key_good;
  logic running;
  logic ring_tick;
  logic xtal_tick;
  logic tick;
  logic illegal;
  logic overflow;

  // ****************************************
  // decode
  // ****************************************
  always_comb
  begin
    mode_access = bus.wr && (bus.addr == MODE_ADDR);
    // byte writes only; bit operations on the mode register are dropped
    mode_commit = mode_access && state.wait_done && !bus.bit_op;
    key_access  = bus.wr && (bus.addr == KEY_ADDR);
    key_good    = key_access && !bus.bit_op && (bus.wdata == KEY_VALUE);
    running     = RING_NONSTOP || !state.mode[CLOCK_STOP_POS];
    ring_tick   = rising(state.ring_sync, state.ring_prev);
    xtal_tick   = rising(state.xtal_sync, state.xtal_prev);
    if (RING_NONSTOP)
    begin
      tick = ring_tick;
    end
    else if (!running || pwr.halt || pwr.stop)
    begin
      tick = 1'b0;
    end
    else if (state.mode[CLOCK_SOURCE_POS])
    begin
      tick = xtal_tick && !pwr.xtal_stopped && !pwr.osc_stabilizing;
    end
    else
    begin
      tick = ring_tick;
    end
    illegal  = running && ((mode_commit && state.mode_written) ||
               (key_access && !key_good));
    overflow = tick && (state.count == terminal_count(state.mode));
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    next_state = state;
    // first flops only feed the second ones
    next_state.ring_meta = ring_osc_in;
    next_state.ring_sync = state.ring_meta;
    next_state.ring_prev = state.ring_sync;
    next_state.xtal_meta = crystal_in;
    next_state.xtal_sync = state.xtal_meta;
    next_state.xtal_prev = state.xtal_sync;
    next_state.wait_done = mode_access && !state.wait_done;
    if (tick)
    begin
      next_state.count = overflow ? '0 : state.count + 1'b1;
    end
    if (mode_commit && !state.mode_written)
    begin
      next_state.mode_written = 1'b1;
      next_state.mode = bus.wdata[4:0];
      if (RING_NONSTOP)
      begin
        next_state.mode[CLOCK_STOP_POS]   = 1'b0;
        next_state.mode[CLOCK_SOURCE_POS] = 1'b0;
      end
    end
    // a clear beats a coincident tick so a restart is never lost
    if (mode_commit)
    begin
      next_state.count = '0;
    end
    if (key_good)
    begin
      next_state.count = '0;
    end
    next_state.rst_pulse = illegal || overflow;
    if (bus.rd)
    begin
      case (bus.addr)
        MODE_ADDR:
        begin
          next_state.rdata = {MODE_FIXED_TOP, state.mode};
        end
        KEY_ADDR:
        begin
          next_state.rdata = KEY_READ_VALUE;
        end
        default:
        begin
          next_state.rdata = UNMAPPED_READ;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= STATE_RESET;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign bus_rdata              = state.rdata;
  assign bus_wait               = mode_access && !state.wait_done;
  assign wdt_reset_req          = state.rst_pulse;
  // the cause flag is a set strobe; the reset-cause register itself lives elsewhere
  assign guard_reset_cause_flag = state.rst_pulse;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // ****************************************
  // register access checks
  // ****************************************

  AST_MODE_READ_TOP: assert property (bus.rd && bus.addr == MODE_ADDR |=> bus_rdata[7:5] == 3'h3)
    else $error("mode readback top bits wrong");

  AST_KEY_READ: assert property (bus.rd && bus.addr == KEY_ADDR |=> bus_rdata == 8'h9A)
    else $error("restart register readback wrong");

  AST_RDATA_HOLD: assert property (!bus.rd |=> bus_rdata == $past(bus_rdata))
    else $error("read data moved without a read");

  AST_WAIT_ONE: assert property (mode_access && !state.wait_done |-> bus_wait ##1 !bus_wait)
    else $error("mode write wait not one cycle");

  AST_WAIT_ONLY_MODE: assert property (bus_wait |-> mode_access)
    else $error("wait outside a mode write");

  AST_FIRST_WRITE_TAKEN: assert property (mode_commit && !state.mode_written
    |=> state.mode_written && state.mode[2:0] == $past(bus.wdata[2:0]))
    else $error("first mode write not stored");

  AST_FIRST_WRITE_QUIET: assert property (mode_commit && !state.mode_written && !overflow
    |=> !wdt_reset_req)
    else $error("first mode write raised reset");

  AST_MODE_LOCK: assert property (state.mode_written |=> state.mode == $past(state.mode))
    else $error("mode changed after first write");

  AST_NONSTOP_RING: assert property (RING_NONSTOP |-> state.mode[4:3] == 2'b00)
    else $error("non-stoppable left ring clock");

  // ****************************************
  // illegal access checks
  // ****************************************

  AST_SECOND_WRITE: assert property (mode_commit && state.mode_written && running |=> wdt_reset_req)
    else $error("second mode write did not reset");

  AST_BAD_KEY: assert property (running && key_access && (bus.bit_op || bus.wdata != 8'hAC) |=> wdt_reset_req)
    else $error("bad key did not reset");

  AST_BITOP_KEY: assert property (running && key_access && bus.bit_op |=> wdt_reset_req)
    else $error("bit access to restart register did not reset");

  AST_STOPPED_QUIET: assert property (!running |=> !wdt_reset_req)
    else $error("reset while stopped");

  AST_STOPPED_KEY: assert property (!running && key_access |=> !wdt_reset_req)
    else $error("restart access while stopped raised reset");

  AST_STOPPED_SECOND: assert property (!running && mode_commit |=> !wdt_reset_req)
    else $error("mode write while stopped raised reset");

  // ****************************************
  // counting checks
  // ****************************************

  AST_MODE_CLEAR: assert property (mode_commit |=> state.count == '0)
    else $error("mode write did not clear counter");

  // an overflow on the same edge still resets, so it is left out here
  AST_KEY_CLEAR: assert property (key_good && !overflow |=> state.count == '0 && !wdt_reset_req)
    else $error("key write did not restart");

  AST_COUNT_STEP: assert property (tick && !overflow && !mode_commit && !key_good
    |=> state.count == $past(state.count) + 1'b1)
    else $error("counter did not step on a tick");

  AST_COUNT_IDLE: assert property (!tick && !mode_commit && !key_good
    |=> state.count == $past(state.count))
    else $error("counter moved without a tick");

  AST_HOLD_STANDBY: assert property (!RING_NONSTOP && (pwr.halt || pwr.stop) && !mode_commit && !key_good
    |=> state.count == $past(state.count))
    else $error("count moved in standby");

  AST_STANDBY_NO_TICK: assert property (!RING_NONSTOP && (pwr.halt || pwr.stop) |-> !tick)
    else $error("tick during standby");

  AST_STOP_NO_TICK: assert property (!RING_NONSTOP && !running |-> !tick)
    else $error("tick while stopped");

  AST_RING_SELECTED: assert property (!RING_NONSTOP && running && !state.mode[CLOCK_SOURCE_POS]
    && !pwr.halt && !pwr.stop |-> tick == ring_tick)
    else $error("ring clock not counted");

  AST_XTAL_SELECTED: assert property (!RING_NONSTOP && running && state.mode[CLOCK_SOURCE_POS]
    && !pwr.halt && !pwr.stop && !pwr.xtal_stopped && !pwr.osc_stabilizing |-> tick == xtal_tick)
    else $error("crystal clock not counted");

  AST_XTAL_PAUSE: assert property (!RING_NONSTOP && state.mode[CLOCK_SOURCE_POS]
    && (pwr.xtal_stopped || pwr.osc_stabilizing) |-> !tick)
    else $error("crystal tick while crystal unavailable");

  AST_NONSTOP_TICKS: assert property (RING_NONSTOP && ring_tick |-> tick)
    else $error("non-stoppable missed a ring tick");

  // ****************************************
  // reset request checks
  // ****************************************

  AST_OVERFLOW: assert property (tick && state.count == terminal_count(state.mode) |=> wdt_reset_req)
    else $error("overflow without reset");

  AST_OVF_WRAP: assert property (overflow && !mode_commit |=> state.count == '0)
    else $error("counter did not wrap on overflow");

  AST_PULSE_ONE: assert property (wdt_reset_req |=> !wdt_reset_req)
    else $error("reset request longer than one cycle");

  AST_PULSE_CAUSE: assert property (wdt_reset_req |-> $past(illegal || overflow))
    else $error("reset request without a cause");

  AST_CAUSE_FLAG: assert property (guard_reset_cause_flag == wdt_reset_req)
    else $error("cause flag differs from reset request");

  COV_OVERFLOW: cover property (overflow ##1 wdt_reset_req);

  COV_RESTART: cover property (key_good ##1 state.count == '0);

  COV_STOPPED: cover property (mode_commit && bus.wdata[4] ##2 !running);

  COV_BAD_KEY: cover property (key_access && !key_good ##1 wdt_reset_req);

  COV_XTAL_TICK: cover property (state.mode[CLOCK_SOURCE_POS] && tick);

endmodule // program_loop_watchdog

`default_nettype wire

// File: hdl/guard_timer_pkg.sv
// constants, bus carrier and state record of the program loop watchdog
// assumes one core clock domain; the bus request is driven from that domain
package guard_timer_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [15:0] MODE_ADDR       = 16'hFF98;
  localparam logic [15:0] KEY_ADDR        = 16'hFF99;
  localparam logic [7:0]  MODE_RESET      = 8'h67;
  localparam logic [7:0]  KEY_READ_VALUE  = 8'h9A;
  localparam logic [7:0]  KEY_VALUE       = 8'hAC;
  localparam logic [2:0]  MODE_FIXED_TOP  = 3'h3;
  localparam logic [7:0]  UNMAPPED_READ   = 8'h00;

  // ****************************************
  // field layout
  // ****************************************
  localparam int CLOCK_STOP_POS    = 4;
  localparam int CLOCK_SOURCE_POS  = 3;
  localparam int INTERVAL_MSB      = 2;
  localparam int RESET_CAUSE_POS   = 4;

  // ****************************************
  // timing
  // ****************************************
  localparam int RING_BASE_EXP     = 11;
  localparam int XTAL_BASE_EXP     = 13;
  localparam int COUNT_W           = 20;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
    logic        bit_op;
  } bus_req_t;

  typedef struct packed {
    logic halt;
    logic stop;
    logic xtal_stopped;
    logic osc_stabilizing;
  } power_state_t;

  typedef struct packed {
    logic               ring_meta;
    logic               ring_sync;
    logic               ring_prev;
    logic               xtal_meta;
    logic               xtal_sync;
    logic               xtal_prev;
    logic [4:0]         mode;
    logic               mode_written;
    logic               wait_done;
    logic [COUNT_W-1:0] count;
    logic               rst_pulse;
    logic [7:0]         rdata;
  } wdt_state_t;

  localparam wdt_state_t STATE_RESET = '{
    ring_meta: 1'b0, ring_sync: 1'b0, ring_prev: 1'b0,
    xtal_meta: 1'b0, xtal_sync: 1'b0, xtal_prev: 1'b0,
    mode: MODE_RESET[4:0], mode_written: 1'b0, wait_done: 1'b0,
    count: '0, rst_pulse: 1'b0, rdata: 8'h00};

endpackage

// File: tb/tb_top.sv
// self-checking bench for the program loop watchdog: registers, keys, overflow, pause, stop
// assumes the design's built-in assertions run alongside; ring pin toggled by the bench
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
  import guard_timer_pkg::*;
  logic         core_clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         ring_osc_in = 1'b0;
  logic         ring_run = 1'b0;
  logic         crystal_in = 1'b0;
  logic         xtal_sel = 1'b0;
  logic         div = 1'b0;
  bus_req_t     bus = '0;
  power_state_t pwr = '0;
  logic [7:0]   bus_rdata;
  logic         bus_wait;
  logic         wdt_reset_req;
  logic         guard_reset_cause_flag;
  logic [31:0]  lfsr = 32'h6955;
  int           n_errors = 0;
  int           checks = 0;
  int           n_rst = 0;
  int           eff = 0;
  int           base;
  int           r;
  always #4 core_clk = ~core_clk;
  program_loop_watchdog i_dut (.core_clk(core_clk), .rst_n(rst_n), .bus(bus), .bus_rdata(bus_rdata),
    .bus_wait(bus_wait), .ring_osc_in(ring_osc_in), .crystal_in(crystal_in), .pwr(pwr),
    .wdt_reset_req(wdt_reset_req), .guard_reset_cause_flag(guard_reset_cause_flag));
  // ****************************************
  // ring pin at a quarter of core rate, effective tick count
  // ****************************************
  always @(posedge core_clk)
  begin
    div <= ~div;
    if (ring_run && div && !xtal_sel)
    begin
      ring_osc_in <= ~ring_osc_in;
      if (!ring_osc_in && !pwr.halt && !pwr.stop) eff <= eff + 1;
    end
    if (ring_run && div && xtal_sel)
    begin
      crystal_in <= ~crystal_in;
      if (!crystal_in && !pwr.halt && !pwr.stop && !pwr.osc_stabilizing) eff <= eff + 1;
    end
  end
  // outputs looked at mid-cycle, away from the edge that launches them
  always @(negedge core_clk)
  begin
    if (wdt_reset_req === 1'b1) n_rst <= n_rst + 1;
    `CHK(guard_reset_cause_flag, wdt_reset_req)
  end
  function automatic logic [31:0] nxt(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic b);
    @(posedge core_clk);
    bus.addr <= a; bus.wdata <= d; bus.wr <= 1'b1; bus.bit_op <= b;
    if (a == MODE_ADDR)
    begin
      #1 `CHK(bus_wait, 1'b1)
      @(posedge core_clk);
    end
    @(posedge core_clk);
    bus.wr <= 1'b0; bus.bit_op <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge core_clk);
    bus.addr <= a; bus.rd <= 1'b1;
    @(posedge core_clk);
    bus.rd <= 1'b0;
    #1 `CHK(bus_rdata, e)
  endtask
  task automatic do_reset();
    @(posedge core_clk);
    rst_n <= 1'b0; ring_run <= 1'b0; pwr <= '0;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'b1;
  endtask
  // waits for one overflow and checks the tick count since base
  // slack: pin sync latency and edges seen by the bench after the overflow
  task automatic ovf(input int exp_ticks);
    r = n_rst;
    ring_run <= 1'b1;
    repeat (40000) if (n_rst == r) @(posedge core_clk);
    ring_run <= 1'b0;
    `CHK(n_rst - r, 1)
    `CHK((eff - base) inside {[exp_ticks - 2:exp_ticks + 3]}, 1'b1)
    $display("test overflow done, ticks %0d", eff - base);
  endtask
  task automatic wrap_up();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial
  begin
    do_reset();
    rd(MODE_ADDR, 8'h67);
    rd(KEY_ADDR, 8'h9A);
    rd(16'hFF9A, 8'h00);
    repeat (4)
    begin
      lfsr = nxt(lfsr);
      r = n_rst;
      wr(KEY_ADDR, (lfsr[7:0] == KEY_VALUE) ? 8'h00 : lfsr[7:0], 1'b0);
      repeat (2) @(posedge core_clk);
      `CHK(n_rst - r, 1)
    end
    r = n_rst;
    wr(KEY_ADDR, KEY_VALUE, 1'b1);
    repeat (2) @(posedge core_clk);
    `CHK(n_rst - r, 1)
    rd(KEY_ADDR, 8'h9A);
    wr(MODE_ADDR, 8'h60, 1'b0);
    rd(MODE_ADDR, 8'h60);
    r = n_rst;
    wr(MODE_ADDR, 8'h67, 1'b0);
    repeat (2) @(posedge core_clk);
    `CHK(n_rst - r, 1)
    rd(MODE_ADDR, 8'h60);
    $display("test registers done");
    do_reset();
    wr(MODE_ADDR, 8'h60, 1'b0);
    base = eff;
    ovf(2 ** RING_BASE_EXP);
    do_reset();
    wr(MODE_ADDR, 8'h60, 1'b0);
    ring_run <= 1'b1;
    repeat (6000) @(posedge core_clk);
    wr(KEY_ADDR, KEY_VALUE, 1'b0);
    base = eff;
    ovf(2 ** RING_BASE_EXP);
    do_reset();
    wr(MODE_ADDR, 8'h60, 1'b0);
    base = eff;
    ring_run <= 1'b1;
    repeat (4000) @(posedge core_clk);
    pwr.halt <= 1'b1;
    repeat (4500) @(posedge core_clk);
    pwr.halt <= 1'b0;
    pwr.stop <= 1'b1;
    repeat (4500) @(posedge core_clk);
    pwr.stop <= 1'b0;
    ovf(2 ** RING_BASE_EXP);
    do_reset();
    xtal_sel <= 1'b1;
    wr(MODE_ADDR, 8'h68, 1'b0);
    rd(MODE_ADDR, 8'h68);
    base = eff;
    ring_run <= 1'b1;
    repeat (8000) @(posedge core_clk);
    pwr.osc_stabilizing <= 1'b1;
    repeat (2000) @(posedge core_clk);
    pwr.osc_stabilizing <= 1'b0;
    ovf(2 ** XTAL_BASE_EXP);
    xtal_sel <= 1'b0;
    do_reset();
    r = n_rst;
    wr(MODE_ADDR, 8'h70, 1'b0);
    wr(KEY_ADDR, 8'h11, 1'b0);
    wr(KEY_ADDR, KEY_VALUE, 1'b1);
    wr(MODE_ADDR, 8'h60, 1'b0);
    ring_run <= 1'b1;
    repeat (9000) @(posedge core_clk);
    `CHK(n_rst - r, 0)
    $display("test stopped done");
    wrap_up();
  end
  initial
  begin
    #760000;
    n_errors++;
    wrap_up();
  end
endmodule // tb_top
`default_nettype wire
